/* verilog/usr_pkg.sv */
// Package for the USB suspend and low-power resume block
package usr_pkg;
    // Register indices on the plain port
    localparam logic [3:0] USR_CTRL_OFF = 4'h0;
    localparam logic [3:0] USR_STAT_OFF = 4'h1;
    localparam logic [3:0] USR_IRQ_STAT_OFF = 4'h2;
    localparam logic [3:0] USR_IRQ_MASK_OFF = 4'h3;
    // Control field positions
    localparam int USR_XCVR_BIT = 0;
    localparam int USR_VREG_BIT = 2;
    localparam int USR_LPRF_BIT = 4;
    localparam int USR_LPRE_BIT = 5;
    localparam int USR_STOP3_BIT = 6;
    // Interrupt status bit positions and register reset values
    localparam int USR_EV_SUSP = 0;
    localparam int USR_EV_RESUME = 1;
    localparam logic [7:0] USR_CTRL_RST = 8'h00;
    localparam logic [1:0] USR_IRQ_RST = 2'h0;
    // Idle time before suspend
    localparam int USR_CLK_MHZ = 250;
    localparam int USR_IDLE_US = 3000;
    localparam int USR_IDLE_CYC = USR_IDLE_US * USR_CLK_MHZ;
    // Bus line state carried together
    typedef struct packed {
        logic dp;
        logic dm;
    } usr_line_t;
    // Line drive request from the serial engine
    typedef struct packed {
        logic oe;
        logic dp;
        logic dm;
    } usr_drive_t;
endpackage : usr_pkg

/* verilog/usr_kdet.sv */
// Clockless K-state latch with two-flop return into the clocked domain
`timescale 1ns/1ps
module usr_kdet (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Arm and line
    input wire logic arm,
    input wire logic k_state,
    // Flag into clocked domain
    output logic flag_sync
);
    logic k_latch;
    logic meta_r;
    logic sync_r;
    // Latch set by the line itself, so no clock is needed
    always_ff @(posedge k_state or negedge arm) begin
        if (!arm) begin
            k_latch <= 1'b0;
        end else begin
            k_latch <= 1'b1;
        end
    end
    // Two-flop synchroniser for the wake level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= k_latch;
            sync_r <= meta_r;
        end
    end
    assign flag_sync = sync_r;
endmodule : usr_kdet

/* verilog/usr_top.sv */
// Suspend detection, low-power resume and line control of the USB device
//
// Functional notes
// - Module may stay available in third stop mode for suspend.
// - Suspend idle flag sets after 3 ms of bus idle while the transceiver is enabled.
// - With resume enable set, a K-state sets the low-power resume flag.
// - Resume flag raises asynchronous wake and re-enables module clocks.
// - Clearing resume enable clears the resume flag.
// - Module stays fully operational in wait mode.
// - Transceiver disabled holds both data lines high impedance.
`timescale 1ns/1ps
module usr_top #(
    parameter int IDLE_CYC = usr_pkg::USR_IDLE_CYC
) (
    // Clock and reset
    clk,
    arst_n,
    // Register port
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    // Bus lines, serial engine side and wait mode
    line_in,
    eng_drive,
    wait_mode,
    // Pins
    dplus_line_o,
    dminus_line_o,
    line_oe,
    // Power, wake and interrupt
    regulator_enable,
    usb_clk_en,
    async_wake,
    irq
);
    import usr_pkg::*;
    input wire logic clk;
    input wire logic arst_n;
    input wire logic [3:0] reg_addr;
    input wire logic [7:0] reg_wdata;
    input wire logic reg_wr;
    input wire logic reg_rd;
    output logic [7:0] reg_rdata;
    input wire usr_pkg::usr_line_t line_in;
    input wire usr_pkg::usr_drive_t eng_drive;
    input wire logic wait_mode;
    output logic dplus_line_o;
    output logic dminus_line_o;
    output logic line_oe;
    output logic regulator_enable;
    output logic usb_clk_en;
    output logic async_wake;
    output logic irq;

    logic rs_meta_r, rst_n;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [31:0] idle_r, idle_nxt;
    logic susp_r, susp_nxt;
    logic [1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
    logic [7:0] rdata_nxt;
    logic lpres_sync, lpres_d_r, susp_d_r;
    logic k_state, line_idle;
    logic transceiver_enable, lowpower_resume_enable;
    logic lowpower_resume_flag, suspend_idle_flag;
    logic dp_nxt, dm_nxt, oe_nxt;
    logic [7:0] stat_word;

    // Reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs_meta_r <= 1'b1;
            rst_n <= rs_meta_r;
        end
    end

    assign transceiver_enable = ctrl_r[USR_XCVR_BIT];
    assign lowpower_resume_enable = ctrl_r[USR_LPRE_BIT];
    assign suspend_idle_flag = susp_r;
    // Full-speed idle is J: D+ high, D- low; K is the reverse
    assign line_idle = line_in.dp & ~line_in.dm;
    assign k_state = ~line_in.dp & line_in.dm;

    // Clockless K latch; cleared whenever the enable is low
    usr_kdet u_kdet (
        .clk(clk),
        .rst_n(rst_n),
        .arm(lowpower_resume_enable & rst_n),
        .k_state(k_state),
        .flag_sync(lpres_sync)
    );
    assign lowpower_resume_flag = lpres_sync;

    // Idle counter and suspend flag; counts in wait mode too
    always_comb begin
        idle_nxt = idle_r;
        susp_nxt = susp_r;
        if (!line_idle || !transceiver_enable) begin
            idle_nxt = '0;
            susp_nxt = 1'b0;
        end else if (idle_r >= 32'(IDLE_CYC - 1)) begin
            susp_nxt = 1'b1;
        end else begin
            idle_nxt = idle_r + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= '0;
            susp_r <= 1'b0;
        end else begin
            idle_r <= idle_nxt;
            susp_r <= susp_nxt;
        end
    end

    // Control, interrupt status and mask registers
    always_comb begin
        ctrl_nxt = ctrl_r;
        imsk_nxt = imsk_r;
        ist_nxt = ist_r;
        if (reg_wr && reg_addr == USR_CTRL_OFF) begin
            ctrl_nxt = reg_wdata;
        end
        if (reg_wr && reg_addr == USR_IRQ_MASK_OFF) begin
            imsk_nxt = reg_wdata[1:0];
        end
        // Flag bit is read-only: it mirrors the clockless latch
        ctrl_nxt[USR_LPRF_BIT] = 1'b0;
        if (reg_wr && reg_addr == USR_IRQ_STAT_OFF) begin
            ist_nxt = ist_r & ~reg_wdata[1:0];
        end
        // Set wins over a same-cycle clear
        if (susp_r && !susp_d_r) begin
            ist_nxt[USR_EV_SUSP] = 1'b1;
        end
        if (lpres_sync && !lpres_d_r) begin
            ist_nxt[USR_EV_RESUME] = 1'b1;
        end
    end

    // Register state and the delayed copies used for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= USR_CTRL_RST;
            imsk_r <= USR_IRQ_RST;
            ist_r <= USR_IRQ_RST;
            lpres_d_r <= 1'b0;
            susp_d_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            imsk_r <= imsk_nxt;
            ist_r <= ist_nxt;
            lpres_d_r <= lpres_sync;
            susp_d_r <= susp_r;
        end
    end

    // Read mux, data valid in the cycle after the strobe
    always_comb begin
        stat_word = 8'h00;
        stat_word[USR_EV_SUSP] = suspend_idle_flag;
        stat_word[USR_EV_RESUME] = lowpower_resume_flag;
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                USR_CTRL_OFF: begin
                    rdata_nxt = ctrl_r;
                    rdata_nxt[USR_LPRF_BIT] = lowpower_resume_flag;
                end
                USR_STAT_OFF: rdata_nxt = stat_word;
                USR_IRQ_STAT_OFF: rdata_nxt = {6'h00, ist_r};
                USR_IRQ_MASK_OFF: rdata_nxt = {6'h00, imsk_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Pin drive: lines float whenever the transceiver is off
    always_comb begin
        oe_nxt = transceiver_enable & eng_drive.oe;
        dp_nxt = oe_nxt & eng_drive.dp;
        dm_nxt = oe_nxt & eng_drive.dm;
    end

    // Output flops; wake path is registered so the clocks restart cleanly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            line_oe <= 1'b0;
            dplus_line_o <= 1'b0;
            dminus_line_o <= 1'b0;
            regulator_enable <= 1'b0;
            usb_clk_en <= 1'b0;
            async_wake <= 1'b0;
            irq <= 1'b0;
        end else begin
            reg_rdata <= rdata_nxt;
            line_oe <= oe_nxt;
            dplus_line_o <= dp_nxt;
            dminus_line_o <= dm_nxt;
            regulator_enable <= ctrl_r[USR_VREG_BIT];
            // Clocks run unless stop3 is requested; wake or wait mode forces them on
            usb_clk_en <= ~ctrl_r[USR_STOP3_BIT] | lowpower_resume_flag | wait_mode;
            async_wake <= lowpower_resume_flag & lowpower_resume_enable;
            irq <= |(ist_r & imsk_r);
        end
    end

    a_lines_float: assert property (@(posedge clk) disable iff (!rst_n)
        !transceiver_enable |=> !line_oe) else $error("lines driven with xcvr off");
    a_suspend_time: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(susp_r) |-> $past(line_idle) && idle_r == 32'(IDLE_CYC - 1))
        else $error("suspend flag early");
    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !lowpower_resume_enable ##1 !lowpower_resume_enable [*3] |-> !lowpower_resume_flag)
        else $error("resume flag kept without enable");
    a_wake_clock: assert property (@(posedge clk) disable iff (!rst_n)
        lowpower_resume_flag |=> usb_clk_en) else $error("clocks not enabled on wake");
    a_wake_out: assert property (@(posedge clk) disable iff (!rst_n)
        lowpower_resume_flag && lowpower_resume_enable |=> async_wake)
        else $error("wake output missing");
    a_resume_event: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lowpower_resume_flag) |=> ist_r[USR_EV_RESUME])
        else $error("resume event not recorded");
    a_wait_clock: assert property (@(posedge clk) disable iff (!rst_n)
        wait_mode |=> usb_clk_en)
        else $error("clocks stopped in wait mode");
endmodule : usr_top

/* tb/usr_host.sv */
// Host model driving the bus lines: idle, resume and traffic
`timescale 1ns/1ps
module usr_host (
    // Clock and mode
    clk,
    mode,
    // Lines toward the device
    line
);
    import usr_pkg::*;
    input wire logic clk;
    input wire logic [1:0] mode;
    output usr_pkg::usr_line_t line;
    logic tog_r = 1'b0;
    // Traffic toggles so the line never stays idle for long
    always @(posedge clk) tog_r <= ~tog_r;
    // Idle J, resume K, otherwise J and SE0 alternating
    always_comb begin
        case (mode)
            2'h0: line = '{dp: 1'b1, dm: 1'b0};
            2'h1: line = '{dp: 1'b0, dm: 1'b1};
            default: line = '{dp: tog_r, dm: 1'b0};
        endcase
    end
endmodule : usr_host

/* tb/tb_top.sv */
// Bench for the suspend and low-power resume block
`timescale 1ns/1ps
module tb_top;
    import usr_pkg::*;
    localparam int IDLE = 50;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    usr_line_t line_in;
    usr_drive_t eng_drive = '0;
    logic wait_mode = 1'b0;
    logic [1:0] host_mode = 2'h2;
    logic dp_o, dm_o, line_oe, vreg, clk_en, wake, irq;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    `define CHK(a, b) chk(8'(a), 8'(b))
    usr_host host (.clk(clk), .mode(host_mode), .line(line_in));
    usr_top #(.IDLE_CYC(IDLE)) dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_in(line_in), .eng_drive(eng_drive), .wait_mode(wait_mode),
        .dplus_line_o(dp_o), .dminus_line_o(dm_o), .line_oe(line_oe),
        .regulator_enable(vreg), .usb_clk_en(clk_en), .async_wake(wake), .irq(irq));
    // Free-running clock
    initial begin
        forever #2 clk = ~clk;
    end
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rchk(logic [3:0] a, logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e);
    endtask : rchk
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(USR_CTRL_OFF, USR_CTRL_RST);
        rchk(USR_IRQ_STAT_OFF, 8'h00);
        rchk(4'hA, 8'h00);
        $display("test reset done");
        // Flag bit is read-only; transceiver gates the pin drive
        wr(USR_CTRL_OFF, 8'h15);
        rchk(USR_CTRL_OFF, 8'h05);
        @(posedge clk);
        eng_drive <= '{oe: 1'b1, dp: 1'b0, dm: 1'b1};
        settle(3);
        `CHK({line_oe, dp_o, dm_o, vreg}, 4'hB);
        wr(USR_CTRL_OFF, 8'h04);
        settle(2);
        `CHK({line_oe, dp_o, dm_o}, 3'h0);
        @(posedge clk);
        eng_drive <= '0;
        $display("test drive done");
        // Suspend after idle, masking and write-one-clear
        wr(USR_CTRL_OFF, 8'h05);
        wr(USR_IRQ_MASK_OFF, 8'h03);
        host_mode <= 2'h0;
        settle(IDLE - 10);
        rchk(USR_STAT_OFF, 8'h00);
        settle(20);
        rchk(USR_STAT_OFF, 8'h01);
        `CHK(irq, 1'b1);
        wr(USR_IRQ_MASK_OFF, 8'h00);
        settle(2);
        `CHK(irq, 1'b0);
        wr(USR_IRQ_STAT_OFF, 8'h01);
        rchk(USR_IRQ_STAT_OFF, 8'h00);
        @(posedge clk);
        host_mode <= 2'h2;
        settle(2);
        rchk(USR_STAT_OFF, 8'h00);
        $display("test suspend done");
        // Low-power resume from stop3
        @(posedge clk);
        host_mode <= 2'h0;
        wr(USR_IRQ_MASK_OFF, 8'h03);
        settle(IDLE + 10);
        wr(USR_CTRL_OFF, 8'h65);
        settle(3);
        `CHK({clk_en, wake}, 2'h0);
        @(posedge clk);
        wait_mode <= 1'b1;
        settle(2);
        `CHK(clk_en, 1'b1);
        @(posedge clk);
        wait_mode <= 1'b0;
        host_mode <= 2'h1;
        settle(5);
        `CHK({wake, clk_en, irq}, 3'h7);
        rchk(USR_CTRL_OFF, 8'h75);
        rchk(USR_STAT_OFF, 8'h02);
        rchk(USR_IRQ_STAT_OFF, 8'h03);
        wr(USR_CTRL_OFF, 8'h05);
        // Flag drops two cycles later, through the synchroniser
        settle(2);
        rchk(USR_CTRL_OFF, 8'h05);
        `CHK(wake, 1'b0);
        wr(USR_IRQ_STAT_OFF, 8'h03);
        $display("test resume done");
        // K without the enable leaves the flag clear
        host_mode <= 2'h0;
        settle(2);
        @(posedge clk);
        eng_drive <= '{oe: 1'b1, dp: 1'b1, dm: 1'b0};
        host_mode <= 2'h1;
        settle(6);
        rchk(USR_STAT_OFF, 8'h00);
        `CHK({wake, irq}, 2'h0);
        wr(USR_CTRL_OFF, 8'h00);
        settle(2);
        `CHK({vreg, line_oe}, 2'h0);
        $display("test no-enable done");
        report_and_stop();
    end
endmodule : tb_top
